// ===== rtl/fwec_controller.v
// Flash write and erase controller: APB registers, word programming and
// page, user-area, full and partial erase sequencing of the flash array.
// Assumes the CPU write port and the flash array run on pclk; the flash
// array presents read data while the read strobe stands, and it is taken at the edge that ends the strobe.
`timescale 1ns/1ps
`include "fwec_defs.vh"

module fwec_controller #(
   parameter WRITE_CYC = (`FWEC_WRITE_NS + `FWEC_CLK_NS - 1) / `FWEC_CLK_NS,
   parameter MS_CYC = `FWEC_NS_PER_MS / `FWEC_CLK_NS,
   parameter PAGE_ERASE_CYC = `FWEC_PAGE_ERASE_MS * MS_CYC,
   parameter FULL_ERASE_CYC = `FWEC_FULL_ERASE_MS * MS_CYC
) (
   input wire pclk,
   input wire presetn,
   input wire ce,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire cpu_wr_req,
   input wire [31:0] cpu_wr_addr,
   input wire [31:0] cpu_wr_data,
   input wire [1:0] cpu_wr_size,
   input wire cpu_fetch_flash,
   output reg cpu_stall,
   output reg cpu_hard_fault,
   input wire [31:0] fl_rdata,
   output reg fl_read,
   output reg fl_prog,
   output reg fl_erase_page,
   output reg fl_erase_user,
   output reg fl_erase_all,
   output reg fl_erase_partial,
   output reg fl_user_sel,
   output reg [31:0] fl_addr,
   output reg [31:0] fl_wdata,
   output reg erase_cycle_done
);

   // ----------------------------------------------------------------
   // State and register declarations
   // ----------------------------------------------------------------
   localparam ST_IDLE = 4'b0001;
   localparam ST_READ = 4'b0010;
   localparam ST_PROG = 4'b0100;
   localparam ST_ERASE = 4'b1000;

   reg [3:0] state_reg;
   reg [1:0] mode_reg;
   reg [31:0] dur_reg;
   reg [31:0] cnt_reg;
   reg [31:0] new_data_reg;
   reg [5:0] page_reg;
   reg part_done;
   reg [`FWEC_NUM_PAGES-1:0] clr_acc;
   reg [`FWEC_NUM_PAGES-1:0] add_acc;
   wire [`FWEC_NUM_PAGES-1:0] acc_wrap;
   wire busy;
   wire apb_wr;
   wire apb_setup;
   wire erase_ok;
   wire cpu_is_user;
   wire cpu_aligned;
   wire [5:0] pw_page;
   wire [31:0] part_cyc;

   assign busy = ~state_reg[0];
   assign apb_setup = psel & ~penable;
   // A write lands only at the access edge, when the master sees pready.
   assign apb_wr = psel & penable & pready & pwrite;
   assign erase_ok = (mode_reg == `FWEC_MODE_ERASE) & ~busy;
   assign cpu_is_user = (cpu_wr_addr[31:12] == `FWEC_USER_BASE);
   assign cpu_aligned = (cpu_wr_size == `FWEC_SIZE_WORD) & (cpu_wr_addr[1:0] == 2'h0);
   assign pw_page = pwdata[`FWEC_PAGE_MSB:`FWEC_PAGE_LSB];
   // Chunk length in cycles; the product is cut to the counter width.
   assign part_cyc = dur_reg * MS_CYC[31:0];

   // ----------------------------------------------------------------
   // APB slave: no wait states, registered answer
   // ----------------------------------------------------------------
   // The answer is prepared in the setup cycle, so every bus output comes
   // from a flip-flop and the access phase lasts exactly one cycle if ce is high in the setup cycle.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (ce) begin
         pready <= apb_setup;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
         if (apb_setup) begin
            if (paddr == `FWEC_OFS_READY_STATUS) begin
               if (!pwrite) begin
                  prdata <= {31'h00000000, ~busy};
               end else begin
                  pslverr <= 1'b1;
               end
            end else if (paddr == `FWEC_OFS_ACCESS_MODE) begin
               prdata <= {30'h00000000, mode_reg};
            end else if (paddr == `FWEC_OFS_PARTIAL_DUR) begin
               prdata <= dur_reg;
            end else if (paddr == `FWEC_OFS_PAGE_ERASE || paddr == `FWEC_OFS_FULL_ERASE ||
                         paddr == `FWEC_OFS_PAGE_ERASE_ALIAS0 ||
                         paddr == `FWEC_OFS_USER_ERASE || paddr == `FWEC_OFS_PARTIAL_ERASE) begin
               // Trigger registers are write-only and read as zero.
               prdata <= 32'h00000000;
            end else begin
               pslverr <= 1'b1;
            end
         end
      end
   end

   // Software settings: access mode and partial chunk length.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_reg <= `FWEC_MODE_READ;
         dur_reg <= `FWEC_RST_PARTIAL_DUR;
      end else if (ce && apb_wr) begin
         if (paddr == `FWEC_OFS_ACCESS_MODE) begin
            mode_reg <= pwdata[1:0];
         end else if (paddr == `FWEC_OFS_PARTIAL_DUR) begin
            dur_reg <= pwdata;
         end
      end
   end

   // ----------------------------------------------------------------
   // Per-page partial erase accumulators
   // ----------------------------------------------------------------
   // Each page keeps its accumulated chunk time in milliseconds. The
   // count is dropped by a full page erase or a full erase, since the
   // page is then cleanly erased and a fresh cycle starts from zero.
   genvar gi;
   generate
      for (gi = 0; gi < `FWEC_NUM_PAGES; gi = gi + 1) begin : g_acc
         reg [31:0] acc_reg;
         wire [31:0] sum;
         assign sum = acc_reg + dur_reg;
         assign acc_wrap[gi] = (sum >= `FWEC_PAGE_ERASE_MS);
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               acc_reg <= 32'h00000000;
            end else if (ce) begin
               if (clr_acc[gi]) begin
                  acc_reg <= 32'h00000000;
               end else if (add_acc[gi]) begin
                  // Overshoot carries over into the next erase cycle.
                  acc_reg <= acc_wrap[gi] ? sum - `FWEC_PAGE_ERASE_MS : sum;
               end
            end
         end
      end
   endgenerate

   // Decode of which accumulators change this cycle.
   always @* begin
      clr_acc = {`FWEC_NUM_PAGES{1'b0}};
      add_acc = {`FWEC_NUM_PAGES{1'b0}};
      part_done = state_reg[3] & fl_erase_partial & (cnt_reg == 32'h00000000);
      if (state_reg[3] && cnt_reg == 32'h00000000) begin
         if (fl_erase_all) begin
            clr_acc = {`FWEC_NUM_PAGES{1'b1}};
         end else if (fl_erase_page && page_reg < `FWEC_NUM_PAGES) begin
            clr_acc[page_reg] = 1'b1;
         end else if (part_done && page_reg < `FWEC_NUM_PAGES) begin
            add_acc[page_reg] = 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Operation sequencer
   // ----------------------------------------------------------------
   // Program is read, merge, write: the old word is ANDed with the new
   // one, so a bit can only fall to 0 even if the array would not stop it.
   // Requests that arrive while busy are dropped; the CPU is stalled while a word programs,
   // and software polls ready before issuing the next erase trigger.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ST_IDLE;
         cnt_reg <= 32'h00000000;
         new_data_reg <= 32'h00000000;
         page_reg <= 6'h00;
         fl_read <= 1'b0;
         fl_prog <= 1'b0;
         fl_erase_page <= 1'b0;
         fl_erase_user <= 1'b0;
         fl_erase_all <= 1'b0;
         fl_erase_partial <= 1'b0;
         fl_user_sel <= 1'b0;
         fl_addr <= 32'h00000000;
         fl_wdata <= 32'h00000000;
         cpu_hard_fault <= 1'b0;
         erase_cycle_done <= 1'b0;
      end else if (ce) begin
         cpu_hard_fault <= 1'b0;
         fl_read <= 1'b0;
         erase_cycle_done <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               if (cpu_wr_req && mode_reg == `FWEC_MODE_WRITE) begin
                  if (cpu_aligned) begin
                     // User area words follow the very same path. Nothing
                     // here feeds live settings; they load at reset and on APB writes.
                     fl_user_sel <= cpu_is_user;
                     fl_addr <= cpu_wr_addr;
                     new_data_reg <= cpu_wr_data;
                     fl_read <= 1'b1;
                     state_reg <= ST_READ;
                  end else begin
                     cpu_hard_fault <= 1'b1;
                  end
               end else if (apb_wr && erase_ok) begin
                  page_reg <= pw_page;
                  fl_addr <= pwdata;
                  fl_user_sel <= 1'b0;
                  if (paddr == `FWEC_OFS_PAGE_ERASE ||
                      paddr == `FWEC_OFS_PAGE_ERASE_ALIAS0) begin
                     fl_erase_page <= 1'b1;
                     cnt_reg <= PAGE_ERASE_CYC[31:0];
                     state_reg <= ST_ERASE;
                  end else if (paddr == `FWEC_OFS_USER_ERASE) begin
                     fl_erase_user <= 1'b1;
                     fl_user_sel <= 1'b1;
                     page_reg <= 6'h3F; // No code page is touched.
                     cnt_reg <= PAGE_ERASE_CYC[31:0];
                     state_reg <= ST_ERASE;
                  end else if (paddr == `FWEC_OFS_FULL_ERASE) begin
                     fl_erase_all <= 1'b1;
                     cnt_reg <= FULL_ERASE_CYC[31:0];
                     state_reg <= ST_ERASE;
                  end else if (paddr == `FWEC_OFS_PARTIAL_ERASE &&
                               pwdata[31:12] != `FWEC_USER_BASE) begin
                     // Page stays undefined until its total reaches a full erase.
                     fl_erase_partial <= 1'b1;
                     cnt_reg <= part_cyc;
                     state_reg <= ST_ERASE;
                  end
               end
            end
            ST_READ: begin
               // Old word arrives now; merge so bits only clear.
               fl_wdata <= fl_rdata & new_data_reg;
               fl_prog <= 1'b1;
               cnt_reg <= WRITE_CYC[31:0];
               state_reg <= ST_PROG;
            end
            ST_PROG: begin
               if (cnt_reg == 32'h00000000) begin
                  fl_prog <= 1'b0;
                  state_reg <= ST_IDLE;
               end else begin
                  cnt_reg <= cnt_reg - 32'h00000001;
               end
            end
            ST_ERASE: begin
               if (cnt_reg == 32'h00000000) begin
                  // A zero-length chunk finishes at once and adds nothing.
                  if (part_done && page_reg < `FWEC_NUM_PAGES) begin
                     erase_cycle_done <= acc_wrap[page_reg];
                  end
                  fl_erase_page <= 1'b0;
                  fl_erase_user <= 1'b0;
                  fl_erase_all <= 1'b0;
                  fl_erase_partial <= 1'b0;
                  state_reg <= ST_IDLE;
               end else begin
                  cnt_reg <= cnt_reg - 32'h00000001;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // CPU stall
   // ----------------------------------------------------------------
   // Programming stalls the CPU outright; erases only block code fetches
   // from flash, so code running from RAM keeps going during long erases.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cpu_stall <= 1'b0;
      end else if (ce) begin
         if (state_reg == ST_IDLE) begin
            cpu_stall <= cpu_wr_req & (mode_reg == `FWEC_MODE_WRITE) & cpu_aligned;
         end else if (state_reg == ST_ERASE) begin
            cpu_stall <= cpu_fetch_flash & (cnt_reg != 32'h00000000);
         end else begin
            cpu_stall <= ~(state_reg[2] & (cnt_reg == 32'h00000000));
         end
      end
   end

endmodule

// ===== rtl/fwec_defs.vh
// Constants for the flash write and erase controller: register offsets,
// field codes, reset values and operation times.
// Assumes a 32-bit APB register port and a 125 MHz pclk.
`ifndef FWEC_DEFS_VH
`define FWEC_DEFS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define FWEC_OFS_READY_STATUS 12'h400
`define FWEC_OFS_ACCESS_MODE 12'h504
`define FWEC_OFS_PAGE_ERASE 12'h508
`define FWEC_OFS_FULL_ERASE 12'h50C
`define FWEC_OFS_PAGE_ERASE_ALIAS0 12'h510
`define FWEC_OFS_USER_ERASE 12'h514
`define FWEC_OFS_PARTIAL_ERASE 12'h518
`define FWEC_OFS_PARTIAL_DUR 12'h51C

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define FWEC_MODE_READ 2'h0
`define FWEC_MODE_WRITE 2'h1
`define FWEC_MODE_ERASE 2'h2
`define FWEC_RST_READY 32'h00000001
`define FWEC_RST_PARTIAL_DUR 32'h0000000A
`define FWEC_PAGE_MSB 17
`define FWEC_PAGE_LSB 12
`define FWEC_NUM_PAGES 48
`define FWEC_USER_BASE 20'h10001
`define FWEC_SIZE_WORD 2'h2

// ----------------------------------------------------------------
// Timing, in printed units
// ----------------------------------------------------------------
`define FWEC_CLK_NS 8
`define FWEC_WRITE_NS 41000
`define FWEC_NS_PER_MS 1000000
`define FWEC_PAGE_ERASE_MS 85
`define FWEC_FULL_ERASE_MS 169

`endif

// ===== tb/fwec_chk.sv
// Port checker for the flash write and erase controller.
// Assumes it is bound into fwec_controller and sees only its ports.
`timescale 1ns/1ps
module fwec_chk #(
   parameter WRITE_CYC = 8
) (
   input wire pclk,
   input wire presetn,
   input wire ce,
   input wire psel,
   input wire penable,
   input wire pready,
   input wire pslverr,
   input wire cpu_wr_req,
   input wire [31:0] cpu_wr_addr,
   input wire [1:0] cpu_wr_size,
   input wire cpu_fetch_flash,
   input wire cpu_stall,
   input wire cpu_hard_fault,
   input wire fl_read,
   input wire fl_prog,
   input wire fl_erase_page,
   input wire fl_erase_user,
   input wire fl_erase_all,
   input wire fl_erase_partial,
   input wire fl_user_sel
);
   // ----------------------------------------------------------
   // Helper logic
   // ----------------------------------------------------------
   // A counter keeps the program length check cheap to evaluate.
   reg [15:0] prog_cnt_reg;
   wire [15:0] prog_cnt_next = fl_prog ? prog_cnt_reg + 16'h0001 : 16'h0000;
   wire erase_any = fl_erase_page | fl_erase_user | fl_erase_all | fl_erase_partial;
   wire bad_req = cpu_wr_size != 2'h2 || cpu_wr_addr[1:0] != 2'h0;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prog_cnt_reg <= 16'h0000;
      end else begin
         prog_cnt_reg <= prog_cnt_next;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ----------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------
   apb_answer_a: assert property (psel && !penable && ce |=> pready)
      else $error("Setup cycle was not answered.");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("Ready stood longer than one cycle.");
   err_qual_a: assert property (pslverr |-> pready)
      else $error("Error flag without ready.");
   prog_stall_a: assert property (fl_prog |-> cpu_stall)
      else $error("Program ran without a stall.");
   prog_len_a: assert property ($fell(fl_prog) |-> prog_cnt_reg == WRITE_CYC + 1)
      else $error("Program length is wrong.");
   prog_order_a: assert property ($rose(fl_prog) |-> $past(fl_read))
      else $error("Program not preceded by a read.");
   bad_drop_a: assert property (cpu_wr_req && bad_req |=> !fl_read && !fl_prog)
      else $error("Bad access reached the array.");
   fault_cause_a: assert property (cpu_hard_fault |-> $past(cpu_wr_req) && $past(bad_req))
      else $error("Hard fault without a bad access.");
   one_op_a: assert property ($onehot0({fl_prog, fl_erase_page, fl_erase_user, fl_erase_all,
      fl_erase_partial}))
      else $error("Two array operations at once.");
   partial_code_a: assert property (fl_erase_partial |-> !fl_user_sel)
      else $error("Partial erase hit the user area.");
   erase_stall_a: assert property (erase_any && $past(erase_any)
      |-> cpu_stall == $past(cpu_fetch_flash))
      else $error("Erase stall does not follow fetch.");
   // Main scenarios reached.
   prog_seen_c: cover property ($rose(fl_prog));
   erase_seen_c: cover property ($rose(fl_erase_page));
   fault_seen_c: cover property (cpu_hard_fault);
endmodule
bind fwec_controller fwec_chk #(.WRITE_CYC(WRITE_CYC)) u_chk (.pclk(pclk),
   .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pready(pready),
   .pslverr(pslverr), .cpu_wr_req(cpu_wr_req), .cpu_wr_addr(cpu_wr_addr),
   .cpu_wr_size(cpu_wr_size), .cpu_fetch_flash(cpu_fetch_flash), .cpu_stall(cpu_stall),
   .cpu_hard_fault(cpu_hard_fault), .fl_read(fl_read), .fl_prog(fl_prog),
   .fl_erase_page(fl_erase_page), .fl_erase_user(fl_erase_user),
   .fl_erase_all(fl_erase_all), .fl_erase_partial(fl_erase_partial),
   .fl_user_sel(fl_user_sel));

// ===== tb/fwec_flash_model.sv
// Behavioural flash array with a user area for the controller's far side.
// Assumes word addresses in bits 17:2 and pages in bits 17:12.
`timescale 1ns/1ps
module fwec_flash_model (
   input wire pclk,
   input wire fl_read,
   input wire fl_prog,
   input wire fl_erase_page,
   input wire fl_erase_user,
   input wire fl_erase_all,
   input wire fl_user_sel,
   input wire [31:0] fl_addr,
   input wire [31:0] fl_wdata,
   input wire erase_cycle_done,
   output logic [31:0] fl_rdata
);
   logic [31:0] mem [0:131071];
   logic [2:0] er_d;
   logic [31:0] scr_reg;
   wire [16:0] idx = {fl_user_sel, fl_addr[17:2]};
   // The word shows while the read strobe stands, so the controller takes it
   // at the edge that ends the strobe; outside a read the line is scrambled.
   assign fl_rdata = fl_read ? mem[idx] : scr_reg;
   initial begin
      foreach (mem[i]) mem[i] = 32'hFFFFFFFF;
      scr_reg = 32'h5A5A5A5A;
      er_d = 3'h0;
   end
   // Page, user and full erases act once at the start; a completed partial cycle wipes its page on erase_cycle_done.
   always @(posedge pclk) begin
      er_d <= {fl_erase_page, fl_erase_user, fl_erase_all};
      scr_reg <= ~scr_reg;
      if (fl_prog) mem[idx] <= mem[idx] & fl_wdata;
      if ((fl_erase_page && !er_d[2]) || erase_cycle_done) begin
         for (int i = 0; i < 1024; i++) mem[{1'h0, fl_addr[17:12], 10'(i)}] = 32'hFFFFFFFF;
      end
      if (fl_erase_user && !er_d[1]) begin
         for (int i = 0; i < 65536; i++) mem[{1'h1, 16'(i)}] = 32'hFFFFFFFF;
      end
      if (fl_erase_all && !er_d[0]) begin
         foreach (mem[i]) mem[i] = 32'hFFFFFFFF;
      end
   end
endmodule

// ===== tb/tb_flash_write_erase_controller.sv
// Self-checking bench: APB driver with an answer queue, CPU writes, array model.
// Assumes the shortened timing parameters set at the instance below.
`timescale 1ns/1ps
`include "fwec_defs.vh"
module tb_flash_write_erase_controller;
   logic pclk, presetn, psel, penable, pwrite, cpu_wr_req, cpu_fetch_flash;
   logic [11:0] paddr;
   logic [31:0] pwdata, cpu_wr_addr, cpu_wr_data, d, d2;
   logic [1:0] cpu_wr_size;
   wire [31:0] prdata, fl_rdata, fl_addr, fl_wdata;
   wire pready, pslverr, cpu_stall, cpu_hard_fault, fl_read, fl_prog, fl_user_sel;
   wire fl_erase_page, fl_erase_user, fl_erase_all, fl_erase_partial, erase_cycle_done;
   wire busy = fl_prog | fl_erase_page | fl_erase_user | fl_erase_all | fl_erase_partial;
   int fails, n_checks, seed, faults, dones;
   logic [33:0] expq [$];
   fwec_controller #(.WRITE_CYC(8), .MS_CYC(4), .PAGE_ERASE_CYC(340), .FULL_ERASE_CYC(676))
   DUT (.pclk(pclk), .presetn(presetn), .ce(1'h1), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cpu_wr_req(cpu_wr_req), .cpu_wr_addr(cpu_wr_addr),
      .cpu_wr_data(cpu_wr_data), .cpu_wr_size(cpu_wr_size), .cpu_fetch_flash(cpu_fetch_flash),
      .cpu_stall(cpu_stall), .cpu_hard_fault(cpu_hard_fault), .fl_rdata(fl_rdata),
      .fl_read(fl_read), .fl_prog(fl_prog), .fl_erase_page(fl_erase_page),
      .fl_erase_user(fl_erase_user), .fl_erase_all(fl_erase_all),
      .fl_erase_partial(fl_erase_partial), .fl_user_sel(fl_user_sel), .fl_addr(fl_addr),
      .fl_wdata(fl_wdata), .erase_cycle_done(erase_cycle_done));
   fwec_flash_model u_flash (.pclk(pclk), .fl_read(fl_read), .fl_prog(fl_prog),
      .fl_erase_page(fl_erase_page), .fl_erase_user(fl_erase_user),
      .fl_erase_all(fl_erase_all), .fl_user_sel(fl_user_sel), .fl_addr(fl_addr),
      .fl_wdata(fl_wdata), .erase_cycle_done(erase_cycle_done), .fl_rdata(fl_rdata));
   // ----------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // One APB transfer; the expected answer is queued for the monitor.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v, input logic e);
      expq.push_back({!w, e, v});
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      @(posedge pclk);
      penable <= 1'h1;
      // Only the watchdog ends this wait if the slave never answers.
      do @(posedge pclk); while (pready !== 1'h1);
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   // Waits, bounded, until no operation or stall is pending.
   task automatic idle();
      repeat (3) @(posedge pclk);
      for (int i = 0; i < 2000 && (busy | cpu_stall) !== 1'h0; i++) @(posedge pclk);
      // Let the closing pulses reach the model and the counters.
      repeat (2) @(posedge pclk);
   endtask
   task automatic cpu_wr(input logic [31:0] a, input logic [31:0] v, input logic [1:0] s);
      @(posedge pclk);
      cpu_wr_req <= 1'h1;
      cpu_wr_addr <= a;
      cpu_wr_data <= v;
      cpu_wr_size <= s;
      @(posedge pclk);
      cpu_wr_req <= 1'h0;
      idle();
   endtask
   // ----------------------------------------------------------
   // Monitor, counters, clock and watchdog
   // ----------------------------------------------------------
   // The queue order matches the driver, so the oldest note is this answer.
   always @(posedge pclk) begin
      logic [33:0] e;
      if (psel && penable && pready === 1'h1) begin
         e = (expq.size() > 0) ? expq.pop_front() : 34'h3FFFFFFFF;
         chk({31'h0, pslverr}, {31'h0, e[32]});
         if (e[33]) chk(prdata, e[31:0]);
      end
      if (cpu_hard_fault === 1'h1) faults++;
      if (erase_cycle_done === 1'h1) dones++;
      cpu_fetch_flash <= 1'($random(seed));
   end
   initial begin
      pclk = 1'h0;
      forever #4 pclk = ~pclk;
   end
   initial begin
      #200000;
      fails++;
      finish_test();
   end
   // ----------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------
   initial begin
      seed = 10;
      {presetn, psel, penable, pwrite, cpu_wr_req, cpu_fetch_flash} = 6'h00;
      {paddr, pwdata, cpu_wr_addr, cpu_wr_data, cpu_wr_size} = 0;
      repeat (8) @(posedge pclk);
      presetn <= 1'h1;
      apb(0, `FWEC_OFS_READY_STATUS, 32'h00000001, 0);
      apb(0, `FWEC_OFS_ACCESS_MODE, 32'h00000000, 0);
      apb(0, `FWEC_OFS_PARTIAL_DUR, 32'h0000000A, 0);
      apb(0, 12'h000, 32'h00000000, 1);
      apb(1, `FWEC_OFS_READY_STATUS, 32'h00000000, 1);
      apb(0, `FWEC_OFS_PAGE_ERASE, 32'h00000000, 0);
      d = $random(seed);
      d2 = $random(seed);
      cpu_wr(32'h00001000, d, 2'h2);
      chk(u_flash.mem[17'h00400], 32'hFFFFFFFF);
      for (int m = 0; m < 3; m++) begin
         apb(1, `FWEC_OFS_ACCESS_MODE, m, 0);
         apb(0, `FWEC_OFS_ACCESS_MODE, m, 0);
      end
      cpu_wr(32'h00001000, d, 2'h2);
      chk(u_flash.mem[17'h00400], 32'hFFFFFFFF);
      apb(1, `FWEC_OFS_ACCESS_MODE, 32'h00000001, 0);
      cpu_wr(32'h00001000, d, 2'h2);
      chk(u_flash.mem[17'h00400], d);
      cpu_wr(32'h00001000, d2, 2'h2);
      chk(u_flash.mem[17'h00400], d & d2);
      cpu_wr(32'h00001006, 32'h00000000, 2'h2);
      cpu_wr(32'h00001004, 32'h00000000, 2'h0);
      chk(faults, 2);
      chk(u_flash.mem[17'h00401], 32'hFFFFFFFF);
      cpu_wr(32'h10001000, d, 2'h2);
      chk(u_flash.mem[17'h10400], d);
      apb(1, `FWEC_OFS_PAGE_ERASE, 32'h00001000, 0);
      apb(0, `FWEC_OFS_READY_STATUS, 32'h00000001, 0);
      apb(1, `FWEC_OFS_ACCESS_MODE, 32'h00000002, 0);
      apb(1, `FWEC_OFS_PAGE_ERASE, 32'h00001000, 0);
      apb(0, `FWEC_OFS_READY_STATUS, 32'h00000000, 0);
      idle();
      chk(u_flash.mem[17'h00400], 32'hFFFFFFFF);
      chk(u_flash.mem[17'h10400], d);
      apb(1, `FWEC_OFS_USER_ERASE, 32'h00000001, 0);
      idle();
      chk(u_flash.mem[17'h10400], 32'hFFFFFFFF);
      apb(1, `FWEC_OFS_ACCESS_MODE, 32'h00000001, 0);
      cpu_wr(32'h10001000, d, 2'h2);
      cpu_wr(32'h00002000, d2, 2'h2);
      apb(1, `FWEC_OFS_ACCESS_MODE, 32'h00000002, 0);
      apb(1, `FWEC_OFS_FULL_ERASE, 32'h00000001, 0);
      idle();
      chk(u_flash.mem[17'h10400] & u_flash.mem[17'h00800], 32'hFFFFFFFF);
      apb(1, `FWEC_OFS_ACCESS_MODE, 32'h00000001, 0);
      cpu_wr(32'h00002004, d, 2'h2);
      apb(1, `FWEC_OFS_ACCESS_MODE, 32'h00000002, 0);
      apb(1, `FWEC_OFS_PARTIAL_DUR, 32'h0000002B, 0);
      apb(0, `FWEC_OFS_PARTIAL_DUR, 32'h0000002B, 0);
      apb(1, `FWEC_OFS_PARTIAL_ERASE, 32'h10001000, 0);
      apb(0, `FWEC_OFS_READY_STATUS, 32'h00000001, 0);
      apb(1, `FWEC_OFS_PARTIAL_ERASE, 32'h00002000, 0);
      apb(0, `FWEC_OFS_READY_STATUS, 32'h00000000, 0);
      idle();
      chk(dones, 0);
      apb(1, `FWEC_OFS_PARTIAL_ERASE, 32'h00002000, 0);
      idle();
      chk(dones, 1);
      chk(u_flash.mem[17'h00801], 32'hFFFFFFFF);
      apb(1, `FWEC_OFS_ACCESS_MODE, 32'h00000000, 0);
      finish_test();
   end
endmodule
